// file: hdl/spl_map.svh
// Purpose: Named constants for the stack pointer limit checker
// Assumes: 16-bit data addresses, word-aligned stack
// Notes:   Definitions only
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH
`define SPL_SFR_TOP    16'h0800
`define SPL_WORD_STEP  16'h0002
`define SPL_SP_RESET   16'h0800
`define SPL_ZERO16     16'h0000
`define SPL_PC_HI_W    7
`define SPL_STATUS_LOW_W 8
`define SPL_CALL_MSB_CLR 16'h7FFF
`define SPL_LIMIT_ALIGN  16'hFFFE
`endif

// file: hdl/spl_pkg.sv
// Purpose: Types for the stack pointer limit checker
// Assumes: Included constants header spl_map.svh
// Notes:   Carrier structs for core requests
package spl_pkg;
	typedef enum logic [1:0] {
		SPL_OP_NONE = 2'b00,
		SPL_OP_PUSH = 2'b01,
		SPL_OP_POP  = 2'b10,
		SPL_OP_EA   = 2'b11
	} spl_op_t;

	typedef enum logic [1:0] {
		SPL_SRC_DATA = 2'b00,
		SPL_SRC_CALL = 2'b01,
		SPL_SRC_EXC  = 2'b10
	} spl_src_t;

	typedef struct packed {
		spl_op_t     op;
		spl_src_t    src;
		logic [15:0] data;
		logic [15:0] ea;
	} spl_req_t;

	typedef struct packed {
		logic [15:0] pcHigh;
		logic [7:0]  statusLowByte;
	} spl_push_info_t;

	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [15:0] addr;
		logic [15:0] wdata;
	} spl_mem_t;
endpackage

// file: hdl/spl_checker.sv
// Purpose: Software stack pointer update and stack bounds checking
// Assumes: Core issues at most one stack request per cycle
// Notes:   Limit register has no reset value; trap is a one-cycle pulse
`timescale 1ns/10ps
`include "spl_map.svh"

// Operation
// - Stack pointer holds first free word; stack grows upward.
// - Push writes then increments; pop decrements then reads.
// - Call push clears the top bit of the pushed counter.
// - Exception push places status low byte above counter high bits.
// - Limit bit 0 reads zero after any write.
// - Limit register gets no value from reset.
// - Every stack-pointer effective address is compared with the limit.
// - Push at sp equal to limit passes; next push traps.
// - Stack pointer address below 0x0800 raises a stack error.
module spl_checker
	import spl_pkg::*;
(
	input  wire logic           core_clk,     // Core clock
	input  wire logic           rst,          // Synchronous reset, active high
	input  wire spl_req_t       req,          // Stack request from the core
	input  wire spl_push_info_t pushInfo,     // Counter high part and status low byte
	input  wire logic           limitWrEn,    // Write strobe for the limit register
	input  wire logic [15:0]    limitWrData,  // Write data for the limit register
	output logic [15:0]         stackPtr,     // Current stack pointer
	output logic [15:0]         stackLimit,   // Limit register readback
	output spl_mem_t            memReq,       // Memory access for push and pop
	output logic                stackTrap     // Stack error trap request
);
	// Request decode
	logic        isPush;
	logic        isPop;
	logic        isEa;
	logic        isStackOp;

	// Stack pointer and its word steps
	logic [15:0] spReg;
	logic [15:0] spNext;
	logic [15:0] spInc;
	logic [15:0] spDec;

	// Limit register, kept out of reset
	logic [15:0] limReg;
	logic [15:0] limNext;

	// Memory access issued for push and pop
	spl_mem_t    memReg;
	spl_mem_t    memNext;

	// Trap request
	logic        trapReg;
	logic        trapNext;

	// Shared bounds check path
	logic [15:0] pushWord;
	logic [15:0] checkAddr;
	logic        overLimit;
	logic        underBase;
	logic        boundFault;

	// One-hot view of the request code
	always_comb begin
		isPush = 1'b0;
		isPop  = 1'b0;
		isEa   = 1'b0;
		unique case (req.op)
			SPL_OP_PUSH: begin
				isPush = 1'b1;
			end
			SPL_OP_POP: begin
				isPop = 1'b1;
			end
			SPL_OP_EA: begin
				isEa = 1'b1;
			end
			SPL_OP_NONE: begin
				isEa = 1'b0;
			end
		endcase
		isStackOp = isPush | isPop | isEa;
	end

	// Post-increment and pre-decrement targets
	always_comb begin
		spInc = spReg + `SPL_WORD_STEP;
		spDec = spReg - `SPL_WORD_STEP;
	end

	// Push data formatting by source
	always_comb begin
		unique case (req.src)
			SPL_SRC_CALL: begin
				pushWord = pushInfo.pcHigh & `SPL_CALL_MSB_CLR;
			end
			SPL_SRC_EXC: begin
				pushWord = {pushInfo.statusLowByte, 1'b0,
					pushInfo.pcHigh[`SPL_PC_HI_W-1:0]};
			end
			default: begin
				pushWord = req.data;
			end
		endcase
	end

	// Address under check; a pop checks the word it is about to read
	always_comb begin
		unique case (req.op)
			SPL_OP_POP: begin
				checkAddr = spDec;
			end
			SPL_OP_EA: begin
				checkAddr = req.ea;
			end
			SPL_OP_PUSH: begin
				checkAddr = spReg;
			end
			SPL_OP_NONE: begin
				checkAddr = spReg;
			end
		endcase
	end

	// Strict greater-than: a push at pointer equal to limit passes
	always_comb begin
		overLimit  = (checkAddr > limReg);
		underBase  = (checkAddr < `SPL_SFR_TOP);
		boundFault = isStackOp & (overLimit | underBase);
	end

	// Pointer moves one word per push or pop
	always_comb begin
		spNext = spReg;
		unique case (req.op)
			SPL_OP_PUSH: begin
				spNext = spInc;
			end
			SPL_OP_POP: begin
				spNext = spDec;
			end
			SPL_OP_EA: begin
				spNext = spReg;
			end
			SPL_OP_NONE: begin
				spNext = spReg;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			spReg <= `SPL_SP_RESET;
		end else begin
			spReg <= spNext;
		end
	end

	// Write strips bit 0 so the limit always holds a word address
	always_comb begin
		limNext = limReg;
		if (limitWrEn) begin
			limNext = limitWrData & `SPL_LIMIT_ALIGN;
		end
	end

	// No reset branch: limit reads unknown until software writes it
	always_ff @(posedge core_clk) begin
		limReg <= limNext;
	end

	// Push writes at the pointer before it moves
	always_comb begin
		memNext.wrEn  = 1'b0;
		memNext.rdEn  = 1'b0;
		memNext.addr  = `SPL_ZERO16;
		memNext.wdata = `SPL_ZERO16;
		unique case (req.op)
			SPL_OP_PUSH: begin
				memNext.wrEn  = 1'b1;
				memNext.addr  = spReg;
				memNext.wdata = pushWord;
			end
			SPL_OP_POP: begin
				memNext.rdEn = 1'b1;
				memNext.addr = spDec;
			end
			SPL_OP_EA: begin
				memNext.wrEn = 1'b0;
			end
			SPL_OP_NONE: begin
				memNext.wrEn = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			memReg.wrEn  <= 1'b0;
			memReg.rdEn  <= 1'b0;
			memReg.addr  <= `SPL_ZERO16;
			memReg.wdata <= `SPL_ZERO16;
		end else begin
			memReg <= memNext;
		end
	end

	// Trap does not hold back the pointer update
	always_comb begin
		trapNext = boundFault;
	end

	// One pulse per offending request, in the cycle after it is checked
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trapReg <= 1'b0;
		end else begin
			trapReg <= trapNext;
		end
	end

	// Outputs straight from their registers
	assign stackPtr   = spReg;
	assign stackLimit = limReg;
	assign memReq     = memReg;
	assign stackTrap  = trapReg;
endmodule

// file: tb/spl_checker_asserts.sv
// Purpose: Port assertions for the stack pointer limit checker
// Assumes: Limit set before requests
// Notes:   Bound into the checker below
`timescale 1ns/10ps
module spl_checker_asserts
	import spl_pkg::*;
(
	input wire logic		core_clk,	// clock
	input wire logic		rst,		// reset
	input wire spl_req_t		req,		// request
	input wire spl_push_info_t	pushInfo,	// push info
	input wire logic		limitWrEn,	// strobe
	input wire logic [15:0]		limitWrData,	// data
	input wire logic [15:0]		stackPtr,	// pointer
	input wire logic [15:0]		stackLimit,	// limit
	input wire spl_mem_t		memReq,		// access
	input wire logic		stackTrap	// trap
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	push_addr_a: assert property (req.op == SPL_OP_PUSH |=>
		memReq.wrEn && memReq.addr == $past(stackPtr)) else $error("push addr");
	push_step_a: assert property (req.op == SPL_OP_PUSH |=>
		stackPtr == $past(stackPtr) + 16'h2) else $error("push step");
	pop_read_a: assert property (req.op == SPL_OP_POP |=>
		memReq.rdEn && memReq.addr == stackPtr && stackPtr == $past(stackPtr) - 16'h2)
		else $error("pop read");
	call_msb_a: assert property (req.op == SPL_OP_PUSH && req.src == SPL_SRC_CALL |=>
		!memReq.wdata[15]) else $error("call msb");
	exc_byte_a: assert property (req.op == SPL_OP_PUSH && req.src == SPL_SRC_EXC |=>
		memReq.wdata[15:8] == $past(pushInfo.statusLowByte)) else $error("exc byte");
	limit_lsb_a: assert property (limitWrEn |=> !stackLimit[0]) else $error("limit lsb");
	push_trap_a: assert property (req.op == SPL_OP_PUSH |=> stackTrap ==
		($past(stackPtr) > $past(stackLimit) || $past(stackPtr) < 16'h0800))
		else $error("push trap");
	ea_trap_a: assert property (req.op == SPL_OP_EA |=> stackTrap ==
		($past(req.ea) > $past(stackLimit) || $past(req.ea) < 16'h0800)) else $error("ea trap");
endmodule
bind spl_checker spl_checker_asserts u_asrt (.*);

// file: tb/spl_core_model.sv
// Purpose: Core request side of the checker
// Assumes: One request per call
// Notes:   Idles between calls
`timescale 1ns/10ps
module spl_core_model
	import spl_pkg::*;
(
	input  wire logic	core_clk,	// clock
	output spl_req_t	req,		// request
	output spl_push_info_t	pushInfo	// push info
);
	initial req = '0;
	initial pushInfo = '0;
	task automatic send(spl_req_t r, spl_push_info_t p);
		@(posedge core_clk);
		req <= r;
		pushInfo <= p;
		@(posedge core_clk);
		req.op <= SPL_OP_NONE;
	endtask
endmodule

// file: tb/stack_pointer_limit_checker_tb_top.sv
// Purpose: Self-checking bench
// Assumes: 20 MHz clock
// Notes:   One idle cycle per request
`timescale 1ns/10ps
module stack_pointer_limit_checker_tb_top;
	import spl_pkg::*;
	logic		core_clk = 0, rst = 1, limitWrEn = 0, stackTrap;
	logic [15:0]	limitWrData = '0, stackPtr, stackLimit;
	spl_req_t	req;
	spl_push_info_t	pushInfo;
	spl_mem_t	memReq;
	int		mismatches = 0, checksDone = 0;
	spl_core_model core (.core_clk(core_clk), .req(req), .pushInfo(pushInfo));
	spl_checker dut (.core_clk(core_clk), .rst(rst), .req(req), .pushInfo(pushInfo),
		.limitWrEn(limitWrEn), .limitWrData(limitWrData), .stackPtr(stackPtr),
		.stackLimit(stackLimit), .memReq(memReq), .stackTrap(stackTrap));
	initial forever #25 core_clk = ~core_clk;
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic step(spl_op_t o, spl_src_t s, logic [15:0] e, sp, w, logic t);
		logic [15:0] acc;
		core.send('{o, s, 16'h1234, e}, '{16'hFFFF, 8'hA5});
		#1;
		acc = {14'h0, o == SPL_OP_PUSH, o == SPL_OP_POP};
		chk(stackPtr, sp);
		chk({15'h0, stackTrap}, {15'h0, t});
		chk({14'h0, memReq.wrEn, memReq.rdEn}, acc);
		if (o == SPL_OP_PUSH) chk(memReq.wdata, w);
		if (o == SPL_OP_PUSH) chk(memReq.addr, sp - 16'h2);
		if (o == SPL_OP_POP) chk(memReq.addr, sp);
	endtask
	task automatic t_limit;
		@(posedge core_clk);
		limitWrEn <= 1'b1;
		limitWrData <= 16'h0805;
		@(posedge core_clk);
		limitWrEn <= 1'b0;
		#1;
		chk(stackLimit, 16'h0804);
		@(posedge core_clk);
		$display("limit test done");
	endtask
	task automatic t_stack;
		step(SPL_OP_PUSH, SPL_SRC_DATA, 0, 16'h0802, 16'h1234, 0);
		step(SPL_OP_PUSH, SPL_SRC_CALL, 0, 16'h0804, 16'h7FFF, 0);
		step(SPL_OP_PUSH, SPL_SRC_EXC, 0, 16'h0806, 16'hA57F, 0);
		step(SPL_OP_PUSH, SPL_SRC_DATA, 0, 16'h0808, 16'h1234, 1);
		step(SPL_OP_POP, SPL_SRC_DATA, 0, 16'h0806, 0, 1);
		step(SPL_OP_POP, SPL_SRC_DATA, 0, 16'h0804, 0, 0);
		step(SPL_OP_POP, SPL_SRC_DATA, 0, 16'h0802, 0, 0);
		step(SPL_OP_POP, SPL_SRC_DATA, 0, 16'h0800, 0, 0);
		step(SPL_OP_POP, SPL_SRC_DATA, 0, 16'h07FE, 0, 1);
		step(SPL_OP_EA, SPL_SRC_DATA, 16'h0804, 16'h07FE, 0, 0);
		step(SPL_OP_EA, SPL_SRC_DATA, 16'h0806, 16'h07FE, 0, 1);
		$display("stack test done");
	endtask
	task automatic t_reset;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk(stackPtr, 16'h0800);
		chk({15'h0, stackTrap}, 16'h0000);
		chk({14'h0, memReq.wrEn, memReq.rdEn}, 16'h0000);
		chk(stackLimit, 16'h0804);
		step(SPL_OP_PUSH, SPL_SRC_DATA, 0, 16'h0802, 16'h1234, 0);
		$display("reset test done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		t_limit;
		t_stack;
		t_reset;
		complete_run;
	end
	initial begin
		#100000;
		mismatches++;
		complete_run;
	end
endmodule
